// File: design/slb_defines.svh
/*
  Constants of the serial byte link: bit timing, frame layout and levels.
  Assumes a 200 MHz device clock; included by the package and the link.
*/
`ifndef SLB_DEFINES_SVH
`define SLB_DEFINES_SVH

// Clock and bit timing, in nanoseconds
`define SLB_CLK_NS 5
`define SLB_BIT_NS 50
`define SLB_BIT_CYCLES (`SLB_BIT_NS / `SLB_CLK_NS)

// Frame layout, bits sent least significant first
`define SLB_DATA_BITS 8
`define SLB_DATA_LEN 4'hB
`define SLB_ACK_LEN 4'h2
`define SLB_START_POS 0
`define SLB_FLAG_POS 1
`define SLB_STOP_POS 10
`define SLB_ACK_FRAME 11'h001

// Levels and buffer depth
`define SLB_IDLE_LEVEL 1'b0
`define SLB_FIFO_DEPTH 2

`endif

// File: design/slb_pkg.sv
/*
  Types shared by the serial byte link and its receive buffer.
  Assumes slb_defines.svh is on the include path.
*/
`include "slb_defines.svh"

package slb_pkg;

  // Transmit state, one-hot
  typedef enum logic [1:0] {
    SLB_TX_IDLE = 2'h1,
    SLB_TX_SHIFT = 2'h2
  } slb_tx_state_type;

  // Receive state, one-hot
  typedef enum logic [1:0] {
    SLB_RX_IDLE = 2'h1,
    SLB_RX_BITS = 2'h2
  } slb_rx_state_type;

  // Frame being shifted onto the wire
  typedef struct packed {
    logic [10:0] bits;
    logic [3:0] len;
  } slb_frame_type;

  // One byte word on the user side
  typedef struct packed {
    logic [7:0] data;
  } slb_byte_type;

endpackage

// File: design/slb_fifo.sv
/*
  Small first-word-first-out buffer with valid and ready on both sides.
  Assumes one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
`include "slb_defines.svh"

module slb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SLB_FIFO_DEPTH
) (
  input wire logic clk, // Device clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Reader takes word
  output logic [WIDTH-1:0] out_data, // Oldest word
  output logic [1:0] count // Words held
);
  import slb_pkg::*;

  // Only a two-deep ring fits the one-bit pointers
  if (DEPTH != 2 || WIDTH < 1)
  begin : g_bad
    $error("slb_fifo supports DEPTH 2 only");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [1:0] next_count;
  logic push, pop;

  // Handshakes; full and empty come straight from the count
  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update
  always_comb
  begin
    next_wr_ptr = push ? ~wr_ptr : wr_ptr;
    next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
    next_count = count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage carries no reset; words are only read when counted
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  AST_FIFO_FULL: assert property (@(posedge clk) disable iff (!rst_b)
    count == 2'h2 |-> !in_ready) else $error("buffer accepts while full");
endmodule

// File: design/slb_link.sv
/*
  Serial byte link end: one outgoing and one incoming wire, framed bytes
  with per-byte acknowledgements and overlapped early acknowledge.
  Assumes the far end is an identical link on its own clock of the same
  rate, and wire inputs already synchronous to clk.
*/
// Behaviour
// - Two one-way wires; one channel out, one channel in.
// - Outgoing wire carries our data packets and our acks for incoming data.
// - A message is a series of bytes, one data packet each.
// - No new data byte until the previous one was acknowledged.
// - Data packet: start bit, a one, eight data bits, stop bit.
// - Ack packet: start bit then stop bit, nothing else.
// - Ack only when the byte is taken and room remains for another.
// - Ack may be sent as soon as a data packet is recognised.
// - Ack during a packet lets the next packet follow at once.
// - Overlap plus buffering sustains about 1.8 and 2.4 Mbytes per second.
`timescale 1ns/1ps
`include "slb_defines.svh"

module slb_link #(
  parameter int BIT_CYCLES = `SLB_BIT_CYCLES
) (
  input wire logic clk, // Device clock, 200 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  output logic link_out, // Outgoing serial wire
  input wire logic link_in, // Incoming serial wire
  input wire logic tx_valid, // Byte offered for sending
  output logic tx_ready, // Byte taken this cycle
  input wire slb_pkg::slb_byte_type tx_byte, // Byte to send
  output logic rx_valid, // Received byte available
  input wire logic rx_ready, // User takes received byte
  output slb_pkg::slb_byte_type rx_byte // Received byte
);
  import slb_pkg::*;

  localparam int HALF_CYCLES = BIT_CYCLES / 2;

  // Timer is eight bits; very short bits break mid-bit sampling
  if (BIT_CYCLES < 4 || BIT_CYCLES > 255)
  begin : g_bad
    $error("BIT_CYCLES must lie in 4..255");
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////
  // Shared flags between the two halves

  logic ack_pend, next_ack_pend; // Ack owed on our wire
  logic ack_wait, next_ack_wait; // Our last byte not yet acknowledged
  logic ack_seen; // Ack packet recognised on the input
  logic ack_issue; // Receive side commits to acknowledge
  logic tx_take_ack; // Transmitter starts an ack packet
  logic tx_take_data; // Transmitter starts a data packet
  logic [1:0] fifo_count;

  ////////////////////////////////////////////////////////////////////////
  // Transmitter

  slb_tx_state_type tx_state, next_tx_state;
  slb_frame_type tx_frame, next_tx_frame;
  logic [7:0] tx_tmr, next_tx_tmr;
  logic [3:0] tx_idx, next_tx_idx;
  logic next_link_out;

  // Acks go first so the far end is never starved of credit
  assign tx_take_ack = (tx_state == SLB_TX_IDLE) && ack_pend;
  assign tx_ready = (tx_state == SLB_TX_IDLE) && !ack_pend && !ack_wait;
  assign tx_take_data = tx_valid && tx_ready;

  // Frame loading and bit shifting
  always_comb
  begin
    next_tx_state = tx_state;
    next_tx_frame = tx_frame;
    next_tx_tmr = tx_tmr;
    next_tx_idx = tx_idx;
    case (tx_state)
      SLB_TX_IDLE:
      begin
        if (tx_take_ack)
        begin
          next_tx_frame = '{bits: `SLB_ACK_FRAME, len: `SLB_ACK_LEN};
          next_tx_state = SLB_TX_SHIFT;
        end
        else if (tx_take_data)
        begin
          // Stop low, data LSB first, flag one, start high
          next_tx_frame = '{bits: {1'b0, tx_byte.data, 1'b1, 1'b1}, len: `SLB_DATA_LEN};
          next_tx_state = SLB_TX_SHIFT;
        end
        next_tx_tmr = 8'(BIT_CYCLES - 1);
        next_tx_idx = 4'h0;
      end
      SLB_TX_SHIFT:
      begin
        if (tx_tmr != 8'h00)
          next_tx_tmr = tx_tmr - 8'h01;
        else if (tx_idx == tx_frame.len - 4'h1)
          next_tx_state = SLB_TX_IDLE;
        else
        begin
          next_tx_tmr = 8'(BIT_CYCLES - 1);
          next_tx_idx = tx_idx + 4'h1;
          next_tx_frame.bits = {1'b0, tx_frame.bits[10:1]};
        end
      end
      default:
        next_tx_state = SLB_TX_IDLE;
    endcase
    // Wire idles low outside packets
    next_link_out = (next_tx_state == SLB_TX_SHIFT) ? next_tx_frame.bits[0]
                                                     : `SLB_IDLE_LEVEL;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_state <= SLB_TX_IDLE;
      tx_frame <= '0;
      tx_tmr <= 8'h00;
      tx_idx <= 4'h0;
      link_out <= 1'b0;
    end
    else
    begin
      tx_state <= next_tx_state;
      tx_frame <= next_tx_frame;
      tx_tmr <= next_tx_tmr;
      tx_idx <= next_tx_idx;
      link_out <= next_link_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Credit and ack bookkeeping

  logic ack_owed, next_ack_owed; // Data recognised, ack not yet issued
  logic byte_in, next_byte_in; // Owed byte already in the buffer
  logic rx_flag_data; // Data packet recognised
  logic rx_push; // Completed byte written to buffer

  // Room for this byte plus one more decides the ack
  assign ack_issue = ack_owed && (byte_in ? (fifo_count <= 2'h1)
                                          : (fifo_count == 2'h0));

  always_comb
  begin
    next_ack_owed = (ack_owed && !ack_issue) || rx_flag_data;
    next_byte_in = (byte_in || (rx_push && ack_owed)) && !ack_issue;
    // A new obligation wins over the transmitter taking the old one
    next_ack_pend = (ack_pend && !tx_take_ack) || ack_issue;
    // Ack during our packet clears the wait so the next byte may follow
    next_ack_wait = (ack_wait && !ack_seen) || tx_take_data;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_owed <= 1'b0;
      byte_in <= 1'b0;
      ack_pend <= 1'b0;
      ack_wait <= 1'b0;
    end
    else
    begin
      ack_owed <= next_ack_owed;
      byte_in <= next_byte_in;
      ack_pend <= next_ack_pend;
      ack_wait <= next_ack_wait;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver, sampling each bit at its middle

  slb_rx_state_type rx_state, next_rx_state;
  logic [7:0] rx_tmr, next_rx_tmr;
  logic [3:0] rx_idx, next_rx_idx;
  logic [7:0] rx_sr, next_rx_sr;
  logic rx_sample;

  assign rx_sample = (rx_state == SLB_RX_BITS) && (rx_tmr == 8'h00);
  assign rx_flag_data = rx_sample && (rx_idx == 4'(`SLB_FLAG_POS)) && link_in;
  assign ack_seen = rx_sample && (rx_idx == 4'(`SLB_FLAG_POS)) && !link_in;
  assign rx_push = rx_sample && (rx_idx == 4'(`SLB_STOP_POS));

  always_comb
  begin
    next_rx_state = rx_state;
    next_rx_tmr = rx_tmr;
    next_rx_idx = rx_idx;
    next_rx_sr = rx_sr;
    case (rx_state)
      SLB_RX_IDLE:
      begin
        // Rising start edge; aim at the middle of the start bit
        if (link_in)
        begin
          next_rx_state = SLB_RX_BITS;
          next_rx_tmr = 8'(HALF_CYCLES - 1);
          next_rx_idx = 4'h0;
        end
      end
      SLB_RX_BITS:
      begin
        if (rx_tmr != 8'h00)
          next_rx_tmr = rx_tmr - 8'h01;
        else
        begin
          next_rx_tmr = 8'(BIT_CYCLES - 1);
          next_rx_idx = rx_idx + 4'h1;
          // A start bit gone low was a glitch; ack and stop end a packet
          if ((rx_idx == 4'(`SLB_START_POS) && !link_in) || ack_seen || rx_push)
            next_rx_state = SLB_RX_IDLE;
          else if (rx_idx > 4'(`SLB_FLAG_POS))
            next_rx_sr = {link_in, rx_sr[7:1]};
        end
      end
      default:
        next_rx_state = SLB_RX_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_state <= SLB_RX_IDLE;
      rx_tmr <= 8'h00;
      rx_idx <= 4'h0;
      rx_sr <= 8'h00;
    end
    else
    begin
      rx_state <= next_rx_state;
      rx_tmr <= next_rx_tmr;
      rx_idx <= next_rx_idx;
      rx_sr <= next_rx_sr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive buffer; credit guarantees room, so a stall loses nothing

  logic fifo_in_ready;
  logic [7:0] fifo_out;

  slb_fifo #(
    .WIDTH(8),
    .DEPTH(`SLB_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(rx_push),
    .in_ready(fifo_in_ready),
    .in_data(rx_sr),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(fifo_out),
    .count(fifo_count)
  );

  assign rx_byte.data = fifo_out;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  AST_IDLE_LOW: assert property (tx_state == SLB_TX_IDLE |-> !link_out)
    else $error("wire not low while idle");
  AST_ONE_OUTSTANDING: assert property (ack_wait |-> !tx_take_data)
    else $error("byte sent before previous ack");
  AST_DATA_FRAME: assert property (tx_take_data |=> link_out ##BIT_CYCLES link_out)
    else $error("data packet lacks start and flag ones");
  AST_ACK_FRAME: assert property (tx_take_ack |=> link_out ##BIT_CYCLES !link_out)
    else $error("ack packet not start then stop");
  AST_ACK_ROOM: assert property (ack_issue |-> fifo_count <= 2'h1)
    else $error("ack issued without room");
  AST_EARLY_ACK: assert property (rx_flag_data && fifo_count == 2'h0 && !ack_owed
    |=> ##1 ack_pend)
    else $error("ack not issued on recognition");
  AST_ACK_RELEASES: assert property (ack_seen && ack_wait && tx_state == SLB_TX_SHIFT
    |=> !ack_wait)
    else $error("ack did not release the transmitter");
  AST_NO_LOSS: assert property (rx_push |-> fifo_in_ready)
    else $error("received byte found buffer full");
  AST_STOP_LOW: assert property (tx_take_data |=> ##(10 * BIT_CYCLES) !link_out)
    else $error("stop bit not low");
endmodule

// File: tb/slb_far_end.sv
/*
  Far-end model of the serial byte link: takes framed bytes on wire_in and
  acks them, promptly or late, and sends its own framed bytes on wire_out.
  Assumes the same clock and bit length as the link it faces.
*/
`timescale 1ns/1ps

module slb_far_end #(
  parameter int BIT_CYCLES = 4
) (
  input wire logic clk, // Shared device clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic wire_in, // Wire from the near end
  output logic wire_out // Wire into the near end
);
  logic [7:0] got_q[$]; // Bytes received, oldest first
  logic [7:0] send_q[$]; // Bytes waiting to go out
  int ack_delay = 0; // Cycles from recognition to ack
  int err_count = 0;
  int acks_seen = 0;
  int cyc = 0;
  int ack_at = 0;
  bit ack_pend = 0;
  bit unacked = 0;
  bit wait_ack = 0;
  logic prev = 1'b0;
  logic [7:0] rx_b;
  logic [10:0] frame;

  initial wire_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle count, used to place late acks
  always @(posedge clk)
    cyc <= cyc + 1;

  // Shift a frame out, first bit first; wire drops back low afterwards
  task automatic shift_out(int n);
    for (int i = 0; i < n; i++)
    begin
      wire_out <= frame[i];
      if (n == 2 && i == 1)
        unacked = 0;
      repeat (BIT_CYCLES) @(posedge clk);
    end
    wire_out <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: rising edge opens a packet, bits sampled near their middle
  initial
  begin
    forever
    begin
      @(posedge clk);
      if (rst_b && wire_in && !prev)
      begin
        repeat (BIT_CYCLES / 2 + BIT_CYCLES) @(posedge clk);
        if (!wire_in)
        begin
          acks_seen++;
          if (!wait_ack)
            err_count++;
          wait_ack = 0;
        end
        else
        begin
          // A second byte recognised before our ack's stop bit began breaks the handshake
          if (unacked)
            err_count++;
          unacked = 1;
          ack_pend = 1;
          ack_at = cyc + ack_delay;
          for (int i = 0; i < 8; i++)
          begin
            repeat (BIT_CYCLES) @(posedge clk);
            rx_b[i] = wire_in;
          end
          repeat (BIT_CYCLES) @(posedge clk);
          if (wire_in !== 1'b0)
            err_count++;
          got_q.push_back(rx_b);
        end
      end
      prev = wire_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sender: acks go before data on the one outgoing wire
  initial
  begin
    forever
    begin
      @(posedge clk);
      if (rst_b && ack_pend && cyc >= ack_at)
      begin
        ack_pend = 0;
        frame = 11'h001;
        shift_out(2);
      end
      else if (rst_b && send_q.size() > 0 && !wait_ack)
      begin
        wait_ack = 1;
        frame = {1'b0, send_q.pop_front(), 2'h3};
        shift_out(11);
      end
    end
  end
endmodule

// File: tb/tb_slb_link.sv
/*
  Self-checking bench for the serial byte link end against a far-end model.
  Assumes slb_pkg and the link and buffer modules are compiled first.
*/
`timescale 1ns/1ps

module tb_slb_link;
  import slb_pkg::*;

  localparam int B = 4;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic link_out;
  logic link_in;
  logic tx_valid = 1'b0;
  logic tx_ready;
  slb_byte_type tx_byte = '0;
  logic rx_valid;
  logic rx_ready = 1'b0;
  slb_byte_type rx_byte;
  bit rx_hold = 1'b0;
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 32'h7db9424c;
  int cyc = 0;
  int span = 0;
  int acks0 = 0;
  logic [7:0] exp_tx[$];
  logic [7:0] exp_rx[$];

  slb_link #(.BIT_CYCLES(B)) i_dut (.clk(clk), .rst_b(rst_b), .link_out(link_out),
    .link_in(link_in), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_byte(rx_byte));

  slb_far_end #(.BIT_CYCLES(B)) i_far (.clk(clk), .rst_b(rst_b), .wire_in(link_out),
    .wire_out(link_in));

  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock and cycle count
  always #2.5 clk = ~clk;

  always @(posedge clk)
    cyc <= cyc + 1;

  // Reader stalls at random so the receive buffer really fills
  always @(posedge clk)
    rx_ready <= !rx_hold && ($random(seed) % 3 != 0);

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Offer n random bytes to the link; span is first offer to last take
  task automatic send_dut(int n, output int sp);
    int t0;
    int w;
    logic [7:0] b;
    t0 = cyc;
    for (int i = 0; i < n; i++)
    begin
      b = 8'($random(seed));
      tx_valid <= 1'b1;
      tx_byte <= slb_byte_type'(b);
      w = 0;
      do
      begin
        @(posedge clk);
        w++;
      end
      while (tx_ready !== 1'b1 && w < 3000);
      if (tx_ready !== 1'b1)
      begin
        fail_count++;
        $display("BAD tx_ready expected 1 seen %b", tx_ready);
      end
      exp_tx.push_back(b);
    end
    tx_valid <= 1'b0;
    sp = cyc - t0;
  endtask

  task automatic far_send(int n);
    logic [7:0] b;
    for (int i = 0; i < n; i++)
    begin
      b = 8'($random(seed));
      exp_rx.push_back(b);
      i_far.send_q.push_back(b);
    end
  endtask

  // Bounded wait until every noted byte has arrived
  task automatic drain(string name);
    int w;
    w = 0;
    while ((exp_tx.size() + exp_rx.size() + i_far.send_q.size() > 0 || i_far.wait_ack)
           && w < 20000)
    begin
      @(posedge clk);
      w++;
    end
    repeat (3 * B) @(posedge clk);
    check("far_errors", 0, 16'(i_far.err_count));
    check("link_idle", 0, link_out);
    check("leftover", 0, 16'(exp_tx.size() + exp_rx.size()));
    $display("Test %s done", name);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: oldest note against each result that appears
  always @(posedge clk)
  begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      check("rx_byte", exp_rx.pop_front(), rx_byte.data);
    if (i_far.got_q.size() > 0)
      check("far_byte", exp_tx.pop_front(), i_far.got_q.pop_front());
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // Prompt acks: bytes follow each other with no wait for the ack
    send_dut(16, span);
    check("stream_fast", 1, span <= 16 * (11 * B + 4));
    drain("prompt");
    // Late acks: each byte must wait for its ack
    i_far.ack_delay = 16 * B;
    send_dut(4, span);
    check("stream_held", 1, span >= 3 * 17 * B);
    drain("late");
    // Reader stalled: first byte acked, second fills buffer, third held
    i_far.ack_delay = 0;
    rx_hold = 1'b1;
    acks0 = i_far.acks_seen;
    far_send(4);
    repeat (70 * B) @(posedge clk);
    check("acks_stalled", 1, 16'(i_far.acks_seen - acks0));
    check("held_bytes", 2, 16'(i_far.send_q.size()));
    check("rx_valid", 1, rx_valid);
    rx_hold = 1'b0;
    drain("stall");
    // Both directions at once, acks interleaved with data
    fork
      send_dut(12, span);
      far_send(12);
    join
    drain("both");
    check("duplex_fast", 1, span <= 12 * (13 * B + 6));
    end_sim();
  end

  // Watchdog: some forty times the expected length of all tests
  initial
  begin
    repeat (90000) @(posedge clk);
    fail_count++;
    end_sim();
  end
endmodule
